// ---- tb/sch_chan_sink.sv ----
`timescale 1ns/100ps
`default_nettype none

module sch_chan_sink
  import sch_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pace: when set, ready only one cycle in four
  input wire logic slow,
  // Stream from the block
  input wire sch_pkg::sch_word_type data,
  input wire logic valid,
  output logic ready
);
  sch_word_type mem [0:255];
  int cnt = 0;
  logic [1:0] phase = 2'h0;

  assign ready = !slow || (phase == 2'h0);

  // Stall pattern moves off the falling edge, like every other input
  always @(negedge clk_sys)
    phase <= phase + 2'h1;

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cnt <= 0;
    else if (valid && ready)
    begin
      mem[cnt[7:0]] <= data;
      cnt <= cnt + 1;
    end
  end
endmodule : sch_chan_sink

`default_nettype wire

// ---- tb/sch_homing_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module sch_homing_tb_top;
  import sch_pkg::*;

  logic clk_sys, rst_b, ce;
  logic [15:0] encSampleIn, encParamIn, decParamIn, decSpeechIn;
  logic encSampleTake, encParamValid, decParamTake, decBadFrame;
  logic decSpeechValid, encSlow, decSlow, encParamReady, decSpeechReady;
  logic encParamOutValid, decSpeechOutValid, encParamOutReady;
  logic decSpeechOutReady, encHomeReset, decHomeReset, encInHome, decInHome;
  logic [6:0] decHomeLag;
  sch_word_type encParamOut, decSpeechOut;
  int num_errors = 0;
  int cmp_count = 0;
  int encRstCnt = 0;
  int decRstCnt = 0;

  sch_homing DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .encSampleIn(encSampleIn), .encSampleTake(encSampleTake),
    .encParamIn(encParamIn), .encParamValid(encParamValid),
    .encParamReady(encParamReady), .encParamOut(encParamOut),
    .encParamOutValid(encParamOutValid),
    .encParamOutReady(encParamOutReady), .decParamIn(decParamIn),
    .decParamTake(decParamTake), .decBadFrame(decBadFrame),
    .decSpeechIn(decSpeechIn), .decSpeechValid(decSpeechValid),
    .decSpeechReady(decSpeechReady), .decSpeechOut(decSpeechOut),
    .decSpeechOutValid(decSpeechOutValid),
    .decSpeechOutReady(decSpeechOutReady), .encHomeReset(encHomeReset),
    .decHomeReset(decHomeReset), .encInHome(encInHome),
    .decInHome(decInHome), .decHomeLag(decHomeLag));

  sch_chan_sink encSink (.clk_sys(clk_sys), .rst_b(rst_b), .slow(encSlow),
    .data(encParamOut), .valid(encParamOutValid), .ready(encParamOutReady));
  sch_chan_sink decSink (.clk_sys(clk_sys), .rst_b(rst_b), .slow(decSlow),
    .data(decSpeechOut), .valid(decSpeechOutValid),
    .ready(decSpeechOutReady));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pulses are counted mid-cycle, where they are settled
  always @(negedge clk_sys)
  begin
    if (encHomeReset === 1'b1)
      encRstCnt++;
    if (decHomeReset === 1'b1)
      decRstCnt++;
  end

  function automatic logic [15:0] homeCode(input int i);
    logic [0:7][15:0] lar;
    int p;
    lar = {16'h0009, 16'h0017, 16'h000F, 16'h0008,
      16'h0007, 16'h0003, 16'h0003, 16'h0002};
    p = (i - 8) % 17;
    if (i < 8)
      return lar[i];
    if (p == 0)
      return 16'h0028;
    if (p < 4)
      return 16'h0000;
    // Pulse 4 of the last sub-frame is the odd one
    if (i == 67)
      return 16'h0003;
    return 16'h0004;
  endfunction : homeCode

  task automatic chk(input logic [16:0] exp, input logic [16:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t ns: expected %h, got %h", $time, exp, got);
    end
  endtask : chk

  task automatic tap(input bit dec, input logic [15:0] w);
    encSampleIn = w;
    decParamIn = w;
    encSampleTake = !dec;
    decParamTake = dec;
    @(negedge clk_sys);
  endtask : tap

  // Held from one falling edge until a rising edge sees ready
  task automatic push(input bit dec, input logic [15:0] w);
    int n;
    n = 0;
    encParamIn = w;
    decSpeechIn = w;
    encParamValid = !dec;
    decSpeechValid = dec;
    while ((dec ? decSpeechReady : encParamReady) !== 1'b1 && n < 1000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 1000)
      num_errors++;
    @(negedge clk_sys);
  endtask : push

  task automatic drain(input bit dec, input int want);
    int n;
    n = 0;
    while ((dec ? decSink.cnt : encSink.cnt) < want && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 3000)
      num_errors++;
    @(negedge clk_sys);
  endtask : drain

  task automatic enc_frame(input logic [15:0] s0, input logic [15:0] s1,
      input bit subst, input bit homed);
    int base, r0;
    base = encSink.cnt;
    r0 = encRstCnt;
    for (int i = 0; i < 160; i++)
      tap(1'b0, (i < 80) ? s0 : s1);
    encSampleTake = 1'b0;
    for (int i = 0; i < 76; i++)
      push(1'b0, 16'h0100 + 16'(i));
    encParamValid = 1'b0;
    drain(1'b0, base + 76);
    for (int i = 0; i < 76; i++)
      chk({subst ? homeCode(i) : 16'h0100 + 16'(i), i == 75},
        encSink.mem[(base + i) % 256]); // params
    chk(17'(homed), 17'(encRstCnt - r0)); // one pulse
    chk(17'(homed), 17'(encInHome)); // home flag
  endtask : enc_frame

  task automatic dec_frame(input bit bad, input int diffAt, input bit subst,
      input bit homed);
    int base, r0;
    base = decSink.cnt;
    r0 = decRstCnt;
    decBadFrame = bad;
    // Bit 15 is never a valid parameter bit, so it carries junk
    for (int i = 0; i < 76; i++)
      tap(1'b1, (homeCode(i) | 16'h8000) ^ 16'(i == diffAt));
    decParamTake = 1'b0;
    for (int i = 0; i < 160; i++)
      push(1'b1, 16'h0C00 + 16'(i));
    decSpeechValid = 1'b0;
    drain(1'b1, base + 160);
    for (int i = 0; i < 160; i++)
      chk({subst ? 16'h0008 : 16'h0C00 + 16'(i), i == 159},
        decSink.mem[(base + i) % 256]); // speech words
    chk(17'(homed), 17'(decRstCnt - r0)); // one pulse
    chk(17'(homed), 17'(decInHome)); // home flag
  endtask : dec_frame

  task automatic test_enc_home;
    enc_frame(16'h000F, 16'h0008, 1'b1, 1'b1); // junk
    $display("test enc_home done");
  endtask : test_enc_home

  task automatic test_enc_misaligned;
    enc_frame(16'h1230, 16'h0008, 1'b0, 1'b0); // second half
    enc_frame(16'h0008, 16'h4440, 1'b0, 1'b0); // first half
    $display("test enc_misaligned done");
  endtask : test_enc_misaligned

  task automatic test_enc_twice_stalled;
    encSlow = 1'b1;
    enc_frame(16'h0008, 16'h0008, 1'b0, 1'b1); // normal output
    enc_frame(16'h0008, 16'h0008, 1'b1, 1'b1); // second frame
    encSlow = 1'b0;
    $display("test enc_twice_stalled done");
  endtask : test_enc_twice_stalled

  // Samples offered while frozen must not shift the frame count
  task automatic test_enc_freeze;
    ce = 1'b0;
    for (int i = 0; i < 80; i++)
      tap(1'b0, 16'h1230);
    chk(17'h00000, 17'(encParamReady)); // frozen, takes no word
    ce = 1'b1;
    enc_frame(16'h0008, 16'h0008, 1'b1, 1'b1); // still aligned
    $display("test enc_freeze done");
  endtask : test_enc_freeze

  task automatic test_dec_home;
    dec_frame(1'b0, -1, 1'b1, 1'b1); // home decoder
    chk(17'h00028, 17'(decHomeLag)); // lag of 40
    $display("test dec_home done");
  endtask : test_dec_home

  task automatic test_dec_bad;
    dec_frame(1'b1, -1, 1'b0, 1'b0); // flagged frame
    $display("test dec_bad done");
  endtask : test_dec_bad

  task automatic test_dec_twice_stalled;
    decSlow = 1'b1;
    dec_frame(1'b0, -1, 1'b0, 1'b1); // from non-home
    dec_frame(1'b0, -1, 1'b1, 1'b1); // second frame
    decSlow = 1'b0;
    $display("test dec_twice_stalled done");
  endtask : test_dec_twice_stalled

  task automatic test_dec_early;
    dec_frame(1'b0, 40, 1'b1, 1'b0); // late difference
    dec_frame(1'b0, 3, 1'b0, 1'b0); // early difference
    $display("test dec_early done");
  endtask : test_dec_early

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // About 4400 cycles are needed; seven times that means a hang
  initial
  begin
    #(32000 * 50);
    num_errors++;
    report_and_stop;
  end

  initial
  begin
    rst_b = 1'b0;
    {encSampleIn, encParamIn, decParamIn, decSpeechIn} = '0;
    {encSampleTake, encParamValid, decParamTake, decBadFrame} = '0;
    {decSpeechValid, encSlow, decSlow} = '0;
    ce = 1'b1;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk(17'h00003, {15'h0000, encInHome, decInHome}); // after reset
    test_enc_home;
    test_enc_misaligned;
    test_enc_twice_stalled;
    test_enc_freeze;
    test_dec_home;
    test_dec_bad;
    test_dec_twice_stalled;
    test_dec_early;
    report_and_stop;
  end
endmodule : sch_homing_tb_top

`default_nettype wire

// ---- verilog/sch_frame_track.sv ----
`timescale 1ns/100ps
`default_nettype none

module sch_frame_track #(
  parameter int LEN = 160,
  parameter int IW = $clog2(LEN)
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Element stream
  input wire logic step,
  input wire logic hit,
  // Frame position and match
  output logic [IW-1:0] idx_q,
  output logic first,
  output logic last,
  output logic matchNow
);

  logic matchSoFar_q;

  assign first = idx_q == '0;
  assign last = idx_q == IW'(LEN - 1);
  // Match over the whole frame so far, this element included
  assign matchNow = matchSoFar_q && hit;

  // Position follows the owner's own frame boundaries
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      idx_q <= '0;
    else if (ce && step)
      idx_q <= last ? '0 : idx_q + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      matchSoFar_q <= 1'b1;
    else if (ce && step)
      matchSoFar_q <= last ? 1'b1 : matchNow;
  end

endmodule : sch_frame_track

`default_nettype wire

// ---- verilog/sch_homing.sv ----
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Encoder homing frame: 160 samples 0x0008
// - Encoder detects homing only on own alignment
// - Encoder emits parameter frame before resetting
// - Encoder resets all state after that frame
// - Home encoder answers with decoder homing frame
// - Homing reflection codes fixed eight values
// - Homing sub-frame codes fixed, one odd pulse
// - Bad frames never trigger decoder homing
// - Home decoder outputs encoder homing frame
// - Decoder resets all state after homing frame
// - Home decoder may detect on early parameters
// - Encoder home state clears its memories
// - Decoder home state: lag 40, memories cleared
// - Homing support is optional
// - Only valid bits are compared
module sch_homing #(
  parameter bit HOMING_EN = 1'b1
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Encoder sample tap
  input wire logic [15:0] encSampleIn,
  input wire logic encSampleTake,
  // Encoder parameters from the encoder datapath
  input wire logic [15:0] encParamIn,
  input wire logic encParamValid,
  output logic encParamReady,
  // Encoder parameters towards the channel
  output sch_pkg::sch_word_type encParamOut,
  output logic encParamOutValid,
  input wire logic encParamOutReady,
  // Decoder parameter tap
  input wire logic [15:0] decParamIn,
  input wire logic decParamTake,
  input wire logic decBadFrame,
  // Decoded speech from the decoder datapath
  input wire logic [15:0] decSpeechIn,
  input wire logic decSpeechValid,
  output logic decSpeechReady,
  // Speech towards the sink
  output sch_pkg::sch_word_type decSpeechOut,
  output logic decSpeechOutValid,
  input wire logic decSpeechOutReady,
  // Homing controls to the datapaths
  output logic encHomeReset,
  output logic decHomeReset,
  output logic encInHome,
  output logic decInHome,
  output logic [6:0] decHomeLag
);

  import sch_pkg::*;

  logic encSmpFire;
  logic encSmpHit;
  logic encSmpFirst;
  logic encSmpLast;
  logic encSmpMatch;
  logic encParFire;
  logic [6:0] encParIdx;
  logic encParLast;
  logic decParFire;
  logic decParHit;
  logic [6:0] decParIdx;
  logic decParFirst;
  logic decParLast;
  logic decParMatch;
  logic decBadNow;
  logic decOutFire;
  logic decOutLast;
  logic encHome_q;
  logic encHomeAtStart_q;
  logic encPendHome_q;
  logic encSubst_q;
  logic decHome_q;
  logic decHomeAtStart_q;
  logic decBad_q;
  logic decPendHome_q;
  logic decSubst_q;
  sch_word_type encBufIn;
  sch_word_type decBufIn;

  assign encSmpFire = encSampleTake && ce;
  assign encParFire = encParamValid && encParamReady && ce;
  assign decParFire = decParamTake && ce;
  assign decOutFire = decSpeechValid && decSpeechReady && ce;
  assign encInHome = encHome_q;
  assign decInHome = decHome_q;
  assign decHomeLag = DEC_HOME_LAG;

  assign encSmpHit = encSampleIn[15:SAMPLE_LSB]
                     == ENC_HOMING_SAMPLE[15:SAMPLE_LSB];
  assign decParHit = ((decParamIn ^ dhfValue(int'(decParIdx)))
                      & paramMask(int'(decParIdx))) == 16'h0000;
  // Bad flag travels with the first parameter of a frame
  assign decBadNow = decParFirst ? decBadFrame : decBad_q;

  sch_frame_track #(.LEN(ENC_FRAME_LEN), .IW(8)) u_encSmpTrk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .step(encSmpFire),
    .hit(encSmpHit),
    .idx_q(),
    .first(encSmpFirst),
    .last(encSmpLast),
    .matchNow(encSmpMatch)
  );

  sch_frame_track #(.LEN(PARAM_FRAME_LEN), .IW(7)) u_encParTrk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .step(encParFire),
    .hit(1'b0),
    .idx_q(encParIdx),
    .first(),
    .last(encParLast),
    .matchNow()
  );

  sch_frame_track #(.LEN(PARAM_FRAME_LEN), .IW(7)) u_decParTrk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .step(decParFire),
    .hit(decParHit),
    .idx_q(decParIdx),
    .first(decParFirst),
    .last(decParLast),
    .matchNow(decParMatch)
  );

  sch_frame_track #(.LEN(DEC_FRAME_LEN), .IW(8)) u_decOutTrk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .step(decOutFire),
    .hit(1'b0),
    .idx_q(),
    .first(),
    .last(decOutLast),
    .matchNow()
  );

  // Encoder frame decision, latched at the last aligned sample
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      encHomeAtStart_q <= 1'b1;
      encPendHome_q <= 1'b0;
      encSubst_q <= 1'b0;
    end
    else if (encSmpFire)
    begin
      if (encSmpFirst)
        encHomeAtStart_q <= encHome_q;
      if (encSmpLast)
      begin
        encPendHome_q <= HOMING_EN && encSmpMatch;
        encSubst_q <= HOMING_EN && encSmpMatch
                      && (encSmpFirst ? encHome_q : encHomeAtStart_q);
      end
    end
  end

  always_comb
  begin
    encBufIn.word = encSubst_q ? dhfValue(int'(encParIdx)) : encParamIn;
    encBufIn.last = encParLast;
  end

  // Reset waits for the last parameter so the frame is out first
  // pulse after frame
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      encHomeReset <= 1'b0;
      encHome_q <= 1'b1;
    end
    else if (ce)
    begin
      encHomeReset <= encParFire && encParLast && encPendHome_q;
      if (encParFire && encParLast)
        encHome_q <= encPendHome_q;
    end
  end

  // Decoder frame decision
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      decHomeAtStart_q <= 1'b1;
      decBad_q <= 1'b0;
      decPendHome_q <= 1'b0;
      decSubst_q <= 1'b0;
    end
    else if (ce)
    begin
      if (decParFire && decParFirst)
      begin
        decHomeAtStart_q <= decHome_q;
        decBad_q <= decBadFrame;
      end
      if (decParFire && decParIdx == 7'(EARLY_LEN - 1))
        decSubst_q <= HOMING_EN && decParMatch && !decBadNow
                      && decHomeAtStart_q;
      else if (decOutFire && decOutLast)
        decSubst_q <= 1'b0;
      if (decParFire && decParLast)
        decPendHome_q <= HOMING_EN && decParMatch && !decBadNow;
      else if (decOutFire && decOutLast)
        decPendHome_q <= 1'b0;
    end
  end

  always_comb
  begin
    decBufIn.word = decSubst_q ? ENC_HOMING_SAMPLE : decSpeechIn;
    decBufIn.last = decOutLast;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      decHomeReset <= 1'b0;
      decHome_q <= 1'b1;
    end
    else if (ce)
    begin
      decHomeReset <= decOutFire && decOutLast && decPendHome_q;
      if (decOutFire && decOutLast)
        decHome_q <= decPendHome_q;
    end
  end

  // Two entries keep full rate; after a one-cycle sink stall the input waits one cycle
  sch_skid_buf #(.WIDTH($bits(sch_word_type)), .DEPTH(2)) u_encBuf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .inData(encBufIn),
    .inValid(encParamValid),
    .inReady(encParamReady),
    .outData(encParamOut),
    .outValid(encParamOutValid),
    .outReady(encParamOutReady)
  );

  sch_skid_buf #(.WIDTH($bits(sch_word_type)), .DEPTH(2)) u_decBuf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .inData(decBufIn),
    .inValid(decSpeechValid),
    .inReady(decSpeechReady),
    .outData(decSpeechOut),
    .outValid(decSpeechOutValid),
    .outReady(decSpeechOutReady)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_enc_reset_after: assert property (
    encHomeReset && $past(ce)
    |-> $past(encParFire && encParLast && encPendHome_q))
    else $error("encoder reset without finished homing frame");

  a_enc_reset_follows: assert property (
    ce && encParFire && encParLast && encPendHome_q
    |=> encHomeReset && encHome_q)
    else $error("encoder reset missing after homing frame");

  a_enc_aligned_only: assert property (
    $rose(encPendHome_q) |-> $past(encSmpFire && encSmpLast && encSmpHit))
    else $error("encoder homing armed off frame boundary");

  a_enc_subst_word: assert property (
    encParFire && encSubst_q && encParIdx == 7'd0
    |-> encBufIn.word == 16'h0009)
    else $error("encoder substitution wrong first code");

  a_dec_bad_frame: assert property (
    decParFire && decParLast && decBadNow |=> !decPendHome_q)
    else $error("bad frame armed decoder homing");

  a_dec_subst_speech: assert property (
    decOutFire && decSubst_q |-> decBufIn.word == 16'h0008)
    else $error("decoder speech not replaced");

  a_dec_reset_pulse: assert property (
    decHomeReset && ce |-> decHome_q ##1 !decHomeReset)
    else $error("decoder reset pulse wrong");

  a_dec_home_clear: assert property (
    ce && decOutFire && decOutLast && !decPendHome_q |=> !decHome_q)
    else $error("decoder home flag not cleared");

  a_dec_home_lag: assert property (
    decHomeLag == 7'd40)
    else $error("decoder home lag not forty");

  c_enc_homing: cover property (encHomeReset);
  c_enc_subst: cover property (encParFire && encSubst_q && encParLast);
  c_dec_subst: cover property (decOutFire && decSubst_q ##[1:400] decHomeReset);
  c_buf_stall: cover property (decSpeechValid && !decSpeechReady);

endmodule : sch_homing

`default_nettype wire

// ---- verilog/sch_pkg.sv ----
`default_nettype none

package sch_pkg;

  // Frame geometry
  localparam int ENC_FRAME_LEN = 160;
  localparam int DEC_FRAME_LEN = 160;
  localparam int PARAM_FRAME_LEN = 76;
  localparam int LAR_COUNT = 8;
  localparam int SUBFRAME_LEN = 17;
  localparam int EARLY_LEN = LAR_COUNT + SUBFRAME_LEN;
  localparam int SAMPLE_W = 16;
  localparam int SAMPLE_VALID_BITS = 13;
  localparam int SAMPLE_LSB = SAMPLE_W - SAMPLE_VALID_BITS;

  // Encoder homing sample, left justified
  localparam logic [15:0] ENC_HOMING_SAMPLE = 16'h0008;

  // Decoder and encoder home state
  localparam logic [6:0] DEC_HOME_LAG = 7'h28;
  localparam int HISTORY_LEN = 120;
  localparam int ENC_LATTICE_LEN = 8;
  localparam int DEC_LATTICE_LEN = 9;

  // Positions inside one sub-frame
  localparam int POS_LAG = 0;
  localparam int POS_GAIN = 1;
  localparam int POS_GRID = 2;
  localparam int POS_AMPL = 3;
  localparam int POS_PULSE0 = 4;
  localparam int HOMING_ODD_SUB = 3;
  localparam int HOMING_ODD_PULSE = 4;

  typedef struct packed {
    logic [15:0] word;
    logic last;
  } sch_word_type;

  // Valid low-order bits of each coded parameter
  function automatic logic [15:0] paramMask(input int idx);
    int pos;
    int width;
    pos = (idx - LAR_COUNT) % SUBFRAME_LEN;
    width = 3;
    if (idx < LAR_COUNT)
      width = 6 - idx / 2;
    else if (pos == POS_LAG)
      width = 7;
    else if (pos == POS_GAIN || pos == POS_GRID)
      width = 2;
    else if (pos == POS_AMPL)
      width = 6;
    return 16'((32'h1 << width) - 1);
  endfunction : paramMask

  // Parameter values of the decoder homing frame
  function automatic logic [15:0] dhfValue(input int idx);
    int pos;
    int sub;
    logic [15:0] value;
    pos = (idx - LAR_COUNT) % SUBFRAME_LEN;
    sub = (idx - LAR_COUNT) / SUBFRAME_LEN;
    value = 16'h0004;
    case (idx)
      0: value = 16'h0009;
      1: value = 16'h0017;
      2: value = 16'h000F;
      3: value = 16'h0008;
      4: value = 16'h0007;
      5: value = 16'h0003;
      6: value = 16'h0003;
      7: value = 16'h0002;
      default:
      begin
        if (pos == POS_LAG)
          value = 16'h0028;
        else if (pos < POS_PULSE0)
          value = 16'h0000;
        else if (sub == HOMING_ODD_SUB && pos == POS_PULSE0 + HOMING_ODD_PULSE)
          value = 16'h0003;
      end
    endcase
    return value;
  endfunction : dhfValue

endpackage : sch_pkg

`default_nettype wire

// ---- verilog/sch_skid_buf.sv ----
`timescale 1ns/100ps
`default_nettype none

module sch_skid_buf #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2,
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Handshake drops while frozen, so no word is lost or taken twice
  assign inReady = ce && (count_q < (AW+1)'(DEPTH));
  assign outValid = ce && (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady && ce;
  assign pop = outValid && outReady && ce;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else if (push)
      mem[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= '0;
    else if (push && !pop)
      count_q <= count_q + 1'b1;
    else if (pop && !push)
      count_q <= count_q - 1'b1;
  end

endmodule : sch_skid_buf

`default_nettype wire
